// >>> include/dbe_pkg.sv
`default_nettype none

package dbe_pkg;

  // ***************************************************************
  // Timing.
  // ***************************************************************

  // System clock rate and the longest internal nonvolatile write time.
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned WRITE_TIME_MS = 5;
  // Cycles spent busy after a write is launched (5 ms at 20 MHz).
  localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_MS * (CLK_HZ / 1000));
  // Width of the busy down-counter, wide enough for WRITE_CYCLES.
  localparam int unsigned BUSY_W        = 17;

  // ***************************************************************
  // Addressing.
  // ***************************************************************

  // Device-type code; the value is arbitrary.
  localparam logic [3:0] DEV_CODE   = 4'h6;
  // Bits per byte on the wire.
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  // Bit positions within the received address byte.
  localparam int unsigned RW_BIT    = 0;
  localparam int unsigned CHOICE_BIT = 1;
  // Reset value of the word address pointer.
  localparam logic [8:0] ADDR_RESET = 9'h000;

  // ***************************************************************
  // Types.
  // ***************************************************************

  // Phases of one serial port.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_ACK_DEV,
    ST_WORD,
    ST_ACK_WORD,
    ST_WDATA,
    ST_ACK_DATA,
    ST_RDATA,
    ST_RACK
  } dbe_state_t;

  // Complete state of one serial port engine.
  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    dbe_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [8:0] addr;
    logic       rw;
    logic       rd_ack;
    logic       wr_pend;
    logic       oe;
    logic       byte_we;
    logic       commit;
    logic [7:0] wdata;
  } dbe_port_t;

  // Memory-side request of one engine.
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       byte_we;
    logic       commit;
  } dbe_mem_t;

  // Complete state of the top level.
  typedef struct packed {
    logic                  mode_m;
    logic                  mode_s;
    logic                  wp_m;
    logic                  wp_s;
    logic [1:0][BUSY_W-1:0] busy_cnt;
  } dbe_top_t;

endpackage

`default_nettype wire

// >>> rtl/dbe_eeprom_slave.sv
// Function
// - Data falling while clock high is a start; a new transaction begins.
// - Data rising while clock high is a stop.
// - A stop during a read ends it and returns to standby.
// - A stop during a write ends capture and launches the internal write.
// - Data changes only while clock low; changes while high are start/stop.
// - Bytes are 8 bits; receiver pulls data low on the ninth clock.
// - No acknowledge while an internal write runs; it lasts at most 5 ms.
// - Upper four address bits match type code, lower three the select bits.
// - On match acknowledge on ninth clock, then read or write per command.
// - On mismatch no acknowledge; standby until the next start.
// - Each bank's select bits default to all zeros.
// - Bank mode uses 8-bit word address and all three select bits.
// - Combine mode uses 9-bit word address; upper two select bits ignored.
// - Combine mode routes address bit 8 low to bank one, high to two.
// - Mode-select pin high gives bank mode, low gives combine mode.
// - Combine mode ignores the second port entirely and never answers there.
// - Combine mode lets the first port reach both banks.
// - Bank mode reaches each bank only through its own port.
// - Write-protect low refuses modification of any location.
// - Reads reach every location regardless of write-protect.
// - Data pins are open-drain pull-downs, released unless driving zero.
// - Each port acts on both edges of its serial clock.
// - In bank mode both ports run independently and concurrently.
// - Command bit one is a read, zero is a write.
`timescale 1ns/100ps
`default_nettype none

module dbe_port_engine (
  input  wire logic           clock,       // System clock.
  input  wire logic           rst_n,       // Asynchronous reset, active low.
  input  wire logic           enable,      // Port may answer.
  input  wire logic           combine,     // Combine addressing in force.
  input  wire logic [2:0]     select,      // Slave-select bits of this port.
  input  wire logic           busy,        // Internal write in progress.
  input  wire logic           wp_ok,       // Writes are allowed.
  input  wire logic           scl_i,       // Serial clock pin level.
  input  wire logic           sda_i,       // Serial data pin level.
  output logic                sda_oe,      // Pull the data line low.
  input  wire logic [7:0]     rd_data,     // Array byte at mem.addr.
  output dbe_pkg::dbe_mem_t   mem          // Array request.
);

  // ***************************************************************
  // State and decoded line events.
  // ***************************************************************

  dbe_pkg::dbe_port_t q;
  dbe_pkg::dbe_port_t d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic addr_match;

  // Events come from the second and third sync stages only, so the first
  // stage never feeds logic; both lines see the same delay.
  assign scl_rise   = q.scl_s & ~q.scl_p;
  assign scl_fall   = ~q.scl_s & q.scl_p;
  assign start_seen = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_seen  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

  // Type code always compared; select bits only in bank mode, since in
  // combine mode the lowest position carries the bank choice bit.
  assign addr_match = (q.sh[7:4] == dbe_pkg::DEV_CODE) &&
                      (combine || (q.sh[3:1] == select));

  // ***************************************************************
  // Next-state logic.
  // ***************************************************************

  // Bits are shifted in on rising edges and driven out on falling edges.
  always_comb begin
    d         = q;
    d.scl_m   = scl_i;
    d.scl_s   = q.scl_m;
    d.scl_p   = q.scl_s;
    d.sda_m   = sda_i;
    d.sda_s   = q.sda_m;
    d.sda_p   = q.sda_s;
    d.byte_we = 1'b0;
    d.commit  = 1'b0;
    if (!enable) begin
      // A disabled port holds standby and never drives its line.
      d.st      = dbe_pkg::ST_IDLE;
      d.oe      = 1'b0;
      d.wr_pend = 1'b0;
    end else if (start_seen) begin
      // A repeated start drops any half-captured write without launching it.
      d.st      = dbe_pkg::ST_DEVADDR;
      d.cnt     = 4'h0;
      d.oe      = 1'b0;
      d.wr_pend = 1'b0;
    end else if (stop_seen) begin
      d.commit  = q.wr_pend;
      d.wr_pend = 1'b0;
      d.st      = dbe_pkg::ST_IDLE;
      d.oe      = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        dbe_pkg::ST_DEVADDR, dbe_pkg::ST_WORD, dbe_pkg::ST_WDATA: begin
          d.sh  = {q.sh[6:0], q.sda_s};
          d.cnt = q.cnt + 4'h1;
        end
        dbe_pkg::ST_RDATA: d.cnt = q.cnt + 4'h1;
        dbe_pkg::ST_RACK:  d.rd_ack = ~q.sda_s;
        default:           d.cnt = q.cnt;
      endcase
    end else if (scl_fall) begin
      case (q.st)
        dbe_pkg::ST_DEVADDR: begin
          if (q.cnt == dbe_pkg::BYTE_BITS) begin
            if (addr_match && !busy) begin
              d.st      = dbe_pkg::ST_ACK_DEV;
              d.oe      = 1'b1;
              d.rw      = q.sh[dbe_pkg::RW_BIT];
              d.addr[8] = combine & q.sh[dbe_pkg::CHOICE_BIT];
            end else begin
              d.st = dbe_pkg::ST_IDLE;
            end
          end
        end
        dbe_pkg::ST_ACK_DEV: begin
          d.cnt = 4'h0;
          if (q.rw) begin
            // Reads ignore write-protect entirely.
            d.sh        = rd_data;
            d.oe        = ~rd_data[7];
            d.addr[7:0] = q.addr[7:0] + 8'h01;
            d.st        = dbe_pkg::ST_RDATA;
          end else begin
            d.oe = 1'b0;
            d.st = dbe_pkg::ST_WORD;
          end
        end
        dbe_pkg::ST_WORD: begin
          if (q.cnt == dbe_pkg::BYTE_BITS) begin
            d.addr[7:0] = q.sh;
            d.oe        = 1'b1;
            d.st        = dbe_pkg::ST_ACK_WORD;
          end
        end
        dbe_pkg::ST_ACK_WORD: begin
          d.oe  = 1'b0;
          d.cnt = 4'h0;
          d.st  = dbe_pkg::ST_WDATA;
        end
        dbe_pkg::ST_WDATA: begin
          if (q.cnt == dbe_pkg::BYTE_BITS) begin
            // Protected bytes are still acknowledged but never stored.
            d.wdata   = q.sh;
            d.byte_we = wp_ok;
            d.wr_pend = q.wr_pend | wp_ok;
            d.oe      = 1'b1;
            d.st      = dbe_pkg::ST_ACK_DATA;
          end
        end
        dbe_pkg::ST_ACK_DATA: begin
          d.addr[7:0] = q.addr[7:0] + 8'h01;
          d.oe        = 1'b0;
          d.cnt       = 4'h0;
          d.st        = dbe_pkg::ST_WDATA;
        end
        dbe_pkg::ST_RDATA: begin
          if (q.cnt == dbe_pkg::BYTE_BITS) begin
            d.oe = 1'b0;
            d.st = dbe_pkg::ST_RACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
          end
        end
        dbe_pkg::ST_RACK: begin
          if (q.rd_ack) begin
            d.sh        = rd_data;
            d.oe        = ~rd_data[7];
            d.addr[7:0] = q.addr[7:0] + 8'h01;
            d.cnt       = 4'h0;
            d.st        = dbe_pkg::ST_RDATA;
          end else begin
            d.st = dbe_pkg::ST_IDLE;
          end
        end
        default: d.oe = 1'b0;
      endcase
    end
  end

  // Sync stages reset high, matching idle pulled-up lines.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.scl_m   <= 1'b1;
      q.scl_s   <= 1'b1;
      q.scl_p   <= 1'b1;
      q.sda_m   <= 1'b1;
      q.sda_s   <= 1'b1;
      q.sda_p   <= 1'b1;
      q.st      <= dbe_pkg::ST_IDLE;
      q.addr    <= dbe_pkg::ADDR_RESET;
    end else begin
      q <= d;
    end
  end

  // Line drive and array request come straight from flip-flops.
  assign sda_oe      = q.oe;
  assign mem.addr    = q.addr;
  assign mem.wdata   = q.wdata;
  assign mem.byte_we = q.byte_we;
  assign mem.commit  = q.commit;

  // ***************************************************************
  // Checks.
  // ***************************************************************

  a_start_restart: assert property (@(posedge clock) disable iff (!rst_n)
    (enable && start_seen) |=> (q.st == dbe_pkg::ST_DEVADDR) && (q.cnt == 4'h0) && !q.oe)
    else $error("Start did not restart address reception.");
  a_stop_standby: assert property (@(posedge clock) disable iff (!rst_n)
    (enable && !start_seen && stop_seen) |=> (q.st == dbe_pkg::ST_IDLE) && !q.oe)
    else $error("Stop did not return the port to standby.");
  a_stop_launch: assert property (@(posedge clock) disable iff (!rst_n)
    (enable && !start_seen && stop_seen && q.wr_pend) |=> q.commit ##1 !q.commit)
    else $error("Stop with captured data did not launch one write.");
  a_match_ack: assert property (@(posedge clock) disable iff (!rst_n)
    (enable && !start_seen && !stop_seen && scl_fall && q.st == dbe_pkg::ST_DEVADDR
     && q.cnt == 4'h8 && addr_match && !busy) |=> (q.st == dbe_pkg::ST_ACK_DEV) && q.oe)
    else $error("Matching address was not acknowledged.");
  a_mismatch_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (enable && !start_seen && !stop_seen && scl_fall && q.st == dbe_pkg::ST_DEVADDR
     && q.cnt == 4'h8 && !addr_match) |=> (q.st == dbe_pkg::ST_IDLE) && !q.oe)
    else $error("Mismatched address did not go to standby.");
  a_busy_noack: assert property (@(posedge clock) disable iff (!rst_n)
    (busy && q.st == dbe_pkg::ST_DEVADDR) |=> (q.st != dbe_pkg::ST_ACK_DEV))
    else $error("Address acknowledged during an internal write.");
  a_wp_nostore: assert property (@(posedge clock) disable iff (!rst_n)
    q.byte_we |-> $past(wp_ok))
    else $error("Byte stored while write-protected.");
  a_off_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !enable |=> !q.oe && (q.st == dbe_pkg::ST_IDLE))
    else $error("Disabled port drove its data line.");
  a_ack_held: assert property (@(posedge clock) disable iff (!rst_n)
    (q.st inside {dbe_pkg::ST_ACK_DEV, dbe_pkg::ST_ACK_WORD, dbe_pkg::ST_ACK_DATA}) |-> q.oe)
    else $error("Acknowledge was not driven through its bit.");

  c_read_ack:  cover property (@(posedge clock) disable iff (!rst_n)
    q.st == dbe_pkg::ST_ACK_DEV && q.rw);
  c_write_go:  cover property (@(posedge clock) disable iff (!rst_n) q.commit);
  c_mismatch:  cover property (@(posedge clock) disable iff (!rst_n)
    q.st == dbe_pkg::ST_DEVADDR ##1 q.st == dbe_pkg::ST_IDLE);

endmodule

module dbe_eeprom_slave #(
  parameter int unsigned WRITE_CYCLES = dbe_pkg::WRITE_CYCLES   // Busy time in cycles.
) (
  input  wire logic       clock,                  // System clock, 20 MHz.
  input  wire logic       rst_n,                  // Asynchronous reset, active low.
  input  wire logic       combine_select_n,       // Pin: high bank mode, low combine.
  input  wire logic       write_protect_n,        // Pin: low forbids writes.
  input  wire logic       first_bank_select_bit2, // Bank one select bit 2.
  input  wire logic       first_bank_select_bit1, // Bank one select bit 1.
  input  wire logic       first_bank_select_bit0, // Bank one select bit 0.
  input  wire logic       second_bank_select_bit2, // Bank two select bit 2.
  input  wire logic       second_bank_select_bit1, // Bank two select bit 1.
  input  wire logic       second_bank_select_bit0, // Bank two select bit 0.
  input  wire logic       bank1_serial_clock,     // Port one clock pin.
  input  wire logic       bank1_serial_data_i,    // Port one data pin level.
  output logic            bank1_serial_data_o,    // Port one data drive value.
  output logic            bank1_serial_data_oe,   // Port one pulls low.
  input  wire logic       bank2_serial_clock,     // Port two clock pin.
  input  wire logic       bank2_serial_data_i,    // Port two data pin level.
  output logic            bank2_serial_data_o,    // Port two data drive value.
  output logic            bank2_serial_data_oe,   // Port two pulls low.
  output dbe_pkg::dbe_mem_t bank1_mem,            // Bank one array request.
  input  wire logic [7:0] bank1_rd_data,          // Bank one array byte.
  output dbe_pkg::dbe_mem_t bank2_mem,            // Bank two array request.
  input  wire logic [7:0] bank2_rd_data,          // Bank two array byte.
  output logic            bank1_busy,             // Bank one writing.
  output logic            bank2_busy              // Bank two writing.
);

  // ***************************************************************
  // Mode pins, busy timers and routing.
  // ***************************************************************

  dbe_pkg::dbe_top_t q;
  dbe_pkg::dbe_top_t d;
  dbe_pkg::dbe_mem_t m1;
  dbe_pkg::dbe_mem_t m2;
  logic       combine;
  logic       hi_bank;
  logic       oe1;
  logic       oe2;
  logic [7:0] rd1;

  assign combine = ~q.mode_s;
  assign hi_bank = combine & m1.addr[8];

  // Timers load on a launched write and count down; busy while nonzero.
  always_comb begin
    d        = q;
    d.mode_m = combine_select_n;
    d.mode_s = q.mode_m;
    d.wp_m   = write_protect_n;
    d.wp_s   = q.wp_m;
    for (int b = 0; b < 2; b++) begin
      if (q.busy_cnt[b] != '0) begin
        d.busy_cnt[b] = q.busy_cnt[b] - {{(dbe_pkg::BUSY_W-1){1'b0}}, 1'b1};
      end
    end
    if (m1.commit) begin
      d.busy_cnt[hi_bank] = WRITE_CYCLES[dbe_pkg::BUSY_W-1:0];
    end
    if (m2.commit) begin
      d.busy_cnt[1] = WRITE_CYCLES[dbe_pkg::BUSY_W-1:0];
    end
  end

  // Pins reset to their inactive levels: bank mode, writes allowed.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q        <= '0;
      q.mode_m <= 1'b1;
      q.mode_s <= 1'b1;
      q.wp_m   <= 1'b1;
      q.wp_s   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bank1_busy = (q.busy_cnt[0] != '0);
  assign bank2_busy = (q.busy_cnt[1] != '0);

  // In combine mode both banks share one port, so either write blocks it.
  dbe_port_engine u_port1 (
    .clock   (clock),
    .rst_n   (rst_n),
    .enable  (1'b1),
    .combine (combine),
    .select  ({first_bank_select_bit2, first_bank_select_bit1,
               first_bank_select_bit0}),
    .busy    (bank1_busy | (combine & bank2_busy)),
    .wp_ok   (q.wp_s),
    .scl_i   (bank1_serial_clock),
    .sda_i   (bank1_serial_data_i),
    .sda_oe  (oe1),
    .rd_data (rd1),
    .mem     (m1)
  );

  // The second port runs apart from the first, only in bank mode.
  dbe_port_engine u_port2 (
    .clock   (clock),
    .rst_n   (rst_n),
    .enable  (~combine),
    .combine (1'b0),
    .select  ({second_bank_select_bit2, second_bank_select_bit1,
               second_bank_select_bit0}),
    .busy    (bank2_busy),
    .wp_ok   (q.wp_s),
    .scl_i   (bank2_serial_clock),
    .sda_i   (bank2_serial_data_i),
    .sda_oe  (oe2),
    .rd_data (bank2_rd_data),
    .mem     (m2)
  );

  // Route the first port to the bank chosen by address bit 8.
  assign rd1 = hi_bank ? bank2_rd_data : bank1_rd_data;

  // Each bank sees only its own port in bank mode.
  always_comb begin
    bank1_mem         = m1;
    bank1_mem.byte_we = m1.byte_we & ~hi_bank;
    bank1_mem.commit  = m1.commit & ~hi_bank;
    bank2_mem         = combine ? m1 : m2;
    bank2_mem.byte_we = combine ? (m1.byte_we & hi_bank) : m2.byte_we;
    bank2_mem.commit  = combine ? (m1.commit & hi_bank) : m2.commit;
  end

  // Open-drain: the driven value is always low.
  assign bank1_serial_data_o  = 1'b0;
  assign bank1_serial_data_oe = oe1;
  assign bank2_serial_data_o  = 1'b0;
  assign bank2_serial_data_oe = oe2;

endmodule

`default_nettype wire

// >>> testbench/dbe_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none

// ***************************************
// Two-wire controller model.
// ***************************************
module dbe_ctl_model (
  input  wire logic lclk, // Link clock.
  input  wire logic sda,  // Resolved data line.
  output logic      scl,  // Serial clock drive.
  output logic      oe    // Pulls data low.
);
  // Lines idle released; the clock stands high between frames.
  initial begin
    scl = 1'b1;
    oe  = 1'b0;
  end

  // Four link cycles per phase keep each phase well above 200 ns.
  task automatic hw();
    repeat (4) @(posedge lclk);
  endtask

  // Data falls while the clock is high; also serves as repeated start.
  task automatic start();
    oe = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    oe = 1'b1;
    hw();
    scl = 1'b0;
    hw();
  endtask

  // Data rises while the clock is high.
  task automatic stop();
    oe = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    oe = 1'b0;
    hw();
  endtask

  // Data moves only in the low phase and is sampled before the fall.
  task automatic bitx(input logic b, output logic s);
    oe = ~b;
    hw();
    scl = 1'b1;
    hw();
    s = sda;
    scl = 1'b0;
    hw();
  endtask

  // Eight bits MSB first, then the ninth clock reads the answer.
  task automatic wbyte(input logic [7:0] b, output logic nk);
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], nk);
    end
    bitx(1'b1, nk);
  endtask

  // Line released for data; last byte ends with no acknowledge.
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, b[i]);
    end
    bitx(last, s);
  endtask
endmodule

`default_nettype wire

// >>> testbench/dbe_eeprom_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dbe_eeprom_slave_tb;
  logic clock, lclk, rst_n, cs_n, wp_n;
  logic [2:0] s1, s2;
  logic c1, c2, o1, o2, d1, d2, l1, l2, z1, z2, busy1, busy2;
  logic [7:0] r1, r2;
  logic [8:0] n_we, n_w2, n_cm, we_a;
  logic [7:0] we_d;
  int bad_count, n_checks;
  dbe_pkg::dbe_mem_t b1m, b2m;

  // ***************************************
  // Clocks, wires and array stand-in.
  // ***************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Link clock is unrelated in phase to the system clock.
  initial begin
    lclk = 1'b0;
    #13;
    forever #40 lclk = ~lclk;
  end
  // Pull-ups: a released line reads high.
  // A driven one would never pull the line, so acks catch a wrong drive value.
  assign l1 = ~(o1 | (d1 & ~z1));
  assign l2 = ~(o2 | (d2 & ~z2));
  // Each bank returns a distinct pattern so routing errors show.
  assign r1 = b1m.addr[7:0] ^ 8'h3C;
  assign r2 = b2m.addr[7:0] ^ 8'hC3;

  dbe_ctl_model i_dbe_ctl_model1 (.lclk(lclk), .sda(l1), .scl(c1), .oe(o1));
  dbe_ctl_model i_dbe_ctl_model2 (.lclk(lclk), .sda(l2), .scl(c2), .oe(o2));
  dbe_eeprom_slave #(.WRITE_CYCLES(400)) i_dbe_eeprom_slave (
    .clock(clock), .rst_n(rst_n), .combine_select_n(cs_n),
    .write_protect_n(wp_n), .first_bank_select_bit2(s1[2]),
    .first_bank_select_bit1(s1[1]), .first_bank_select_bit0(s1[0]),
    .second_bank_select_bit2(s2[2]), .second_bank_select_bit1(s2[1]),
    .second_bank_select_bit0(s2[0]), .bank1_serial_clock(c1),
    .bank1_serial_data_i(l1), .bank1_serial_data_o(z1),
    .bank1_serial_data_oe(d1), .bank2_serial_clock(c2),
    .bank2_serial_data_i(l2), .bank2_serial_data_o(z2),
    .bank2_serial_data_oe(d2), .bank1_mem(b1m), .bank1_rd_data(r1),
    .bank2_mem(b2m), .bank2_rd_data(r2), .bank1_busy(busy1),
    .bank2_busy(busy2));

  // Stored bytes and write launches are counted as they happen.
  always @(posedge clock) begin
    if (b1m.byte_we === 1'b1) begin
      n_we++;
      we_a = b1m.addr;
      we_d = b1m.wdata;
    end
    if (b2m.byte_we === 1'b1) begin
      n_w2++;
      we_a = b2m.addr;
      we_d = b2m.wdata;
    end
    if (b1m.commit === 1'b1 || b2m.commit === 1'b1) n_cm++;
  end

  // ***************************************
  // Access and compare tasks.
  // ***************************************
  task automatic chk(input string n, input logic [8:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic sel(input logic p, input logic [7:0] a, output logic k);
    if (p) begin i_dbe_ctl_model2.start(); i_dbe_ctl_model2.wbyte(a, k); end
    else begin i_dbe_ctl_model1.start(); i_dbe_ctl_model1.wbyte(a, k); end
  endtask
  task automatic wb(input logic p, input logic [7:0] b, output logic k);
    if (p) i_dbe_ctl_model2.wbyte(b, k);
    else i_dbe_ctl_model1.wbyte(b, k);
  endtask
  task automatic stp(input logic p);
    if (p) i_dbe_ctl_model2.stop();
    else i_dbe_ctl_model1.stop();
  endtask
  // Byte write; every byte must be acknowledged.
  task automatic wr(input logic p, input logic [6:0] d, input logic [7:0] w, v);
    logic k;
    sel(p, {d, 1'b0}, k);
    chk("dev ack", 9'h000, {8'h00, k});
    wb(p, w, k);
    chk("word ack", 9'h000, {8'h00, k});
    wb(p, v, k);
    chk("data ack", 9'h000, {8'h00, k});
    stp(p);
  endtask
  // Random read: dummy write, repeated start, one byte, no ack, stop.
  task automatic rd(input logic p, input logic [6:0] d, input logic [7:0] w, e);
    logic k;
    logic [7:0] b;
    sel(p, {d, 1'b0}, k);
    wb(p, w, k);
    sel(p, {d, 1'b1}, k);
    chk("read ack", 9'h000, {8'h00, k});
    if (p) i_dbe_ctl_model2.rbyte(1'b1, b);
    else i_dbe_ctl_model1.rbyte(1'b1, b);
    chk("read data", {1'b0, e}, {1'b0, b});
    stp(p);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ***************************************
  // Test sequence.
  // ***************************************
  initial begin
    logic k;
    {rst_n, cs_n, wp_n, s1, s2} = {3'b011, 3'h0, 3'h5};
    {n_we, n_w2, n_cm, we_a, we_d} = '0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    wr(1'b0, {dbe_pkg::DEV_CODE, 3'h0}, 8'h05, 8'hA5);
    repeat (4) @(negedge clock);
    chk("we addr", 9'h005, we_a);
    chk("we data", 9'h0A5, {1'b0, we_d});
    chk("commits", 9'h001, n_cm);
    chk("busy", 9'h001, {8'h00, busy1});
    sel(1'b0, {dbe_pkg::DEV_CODE, 4'h0}, k);
    chk("busy nack", 9'h001, {8'h00, k});
    stp(1'b0);
    for (int i = 0; i < 600 && busy1 !== 1'b0; i++) @(negedge clock);
    chk("busy end", 9'h000, {8'h00, busy1});
    sel(1'b0, {dbe_pkg::DEV_CODE, 4'h3}, k);
    chk("sel nack", 9'h001, {8'h00, k});
    stp(1'b0);
    sel(1'b0, {~dbe_pkg::DEV_CODE, 4'h1}, k);
    chk("code nack", 9'h001, {8'h00, k});
    stp(1'b0);
    @(negedge clock);
    wp_n = 1'b0;
    wr(1'b0, {dbe_pkg::DEV_CODE, 3'h0}, 8'h20, 8'h11);
    repeat (4) @(negedge clock);
    chk("wp writes", 9'h001, n_we);
    chk("wp commits", 9'h001, n_cm);
    fork
      rd(1'b0, {dbe_pkg::DEV_CODE, 3'h0}, 8'h10, 8'h2C);
      rd(1'b1, {dbe_pkg::DEV_CODE, 3'h5}, 8'h33, 8'hF0);
    join
    @(negedge clock);
    {cs_n, wp_n} = 2'b01;
    repeat (4) @(negedge clock);
    rd(1'b0, {dbe_pkg::DEV_CODE, 3'h7}, 8'h44, 8'h87);
    rd(1'b0, {dbe_pkg::DEV_CODE, 3'h4}, 8'h44, 8'h78);
    sel(1'b1, {dbe_pkg::DEV_CODE, 4'hA}, k);
    chk("port2 nack", 9'h001, {8'h00, k});
    stp(1'b1);
    // Combine-mode write with address bit 8 set must land in bank two only.
    wr(1'b0, {dbe_pkg::DEV_CODE, 3'h1}, 8'h07, 8'h5A);
    repeat (4) @(negedge clock);
    chk("bank2 we", 9'h001, n_w2);
    chk("bank2 addr", 9'h107, we_a);
    chk("bank2 data", 9'h05A, {1'b0, we_d});
    chk("bank1 we", 9'h001, n_we);
    chk("bank2 commits", 9'h002, n_cm);
    chk("bank2 busy", 9'h002, {7'h00, busy2, busy1});
    // The shared port must refuse while the second bank is still writing.
    sel(1'b0, {dbe_pkg::DEV_CODE, 4'h0}, k);
    chk("comb busy nack", 9'h001, {8'h00, k});
    stp(1'b0);
    results();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    results();
  end
endmodule

`default_nettype wire
